// >>> logic/sm_dev.sv
// Slave-only serial memory device: framing, addressing, page buffer, write cycle
`timescale 1ns/1ps
// Contract
// RL1 - Change data only while clock is low
// RL2 - Detect START and STOP while clock high
// RL3 - Master alone makes clock, START, STOP
// RL4 - Eight bits MSB first, then acknowledge
// RL5 - Control code 1010 and straps must match
// RL6 - Last control bit: one read, zero write
// RL7 - Acknowledge matching control byte on ninth clock
// RL8 - Two address bytes, thirteen bits used
// RL9 - Acknowledge every byte; master restarts on none
// RL10 - Load address pointer after low byte
// RL11 - Write only after STOP, else discard
// RL12 - No control acknowledge while write busy
// RL13 - Pointer advances, wrapping within 32-byte page
// RL14 - Page write up to 32 bytes
// RL15 - Page buffer index wraps past 32 bytes
// RL16 - Pointer never crosses page boundary
// RL17 - Protected: acknowledge all, start no write
// RL18 - Protected: pointer still advances after STOP
// RL19 - Protect pin sampled at STOP only
// RL20 - Page programmed byte by byte
// RL21 - Power-on delay before answering bus
// RL22 - Unmatched control byte: stay released until START
module sm_dev #(
  parameter int POR_CYC = sm_pkg::POR_CYC_I,
  parameter int WR_CYC  = sm_pkg::BYTE_WR_CYC
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  sm_if.dev               link,
  input  wire logic       select_strap_bit0,
  input  wire logic       select_strap_bit1,
  input  wire logic       select_strap_bit2,
  input  wire logic       write_protect,
  output logic            busy,
  output logic            ready,
  output logic [12:0]     pointer
);
  typedef struct packed {
    logic [1:0]        scl_s;
    logic [1:0]        sda_s;
    logic [1:0]        wp_s;
    logic [1:0]        st0_s;
    logic [1:0]        st1_s;
    logic [1:0]        st2_s;
    logic              scl_q;
    logic              sda_q;
    sm_pkg::sm_phase_e phase;
    logic [3:0]        bitn;
    logic [7:0]        shreg;
    logic              ack_pend;
    logic              ack_drive;
    logic              sda_oe_n;
    logic [4:0]        addr_hi;
    logic [12:0]       ptr;
    logic [12:0]       base;
    logic [4:0]        wr_idx;
    logic [5:0]        count;
    logic              busy;
    logic [4:0]        prog_idx;
    logic [5:0]        prog_left;
    logic [15:0]       wait_cnt;
    logic              ready;
  } sm_dev_s;
  sm_dev_s st;
  sm_dev_s next_st;
  logic [7:0] page_buf [sm_pkg::PAGE_BYTES];
  logic [7:0] mem [sm_pkg::MEM_BYTES];
  logic       buf_we;
  logic       mem_we;
  logic [12:0] mem_addr;
  logic       scl;
  logic       sda;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic [7:0] rx_byte;
  logic [2:0] straps;

  // Second stage only is read; first stage feeds nothing else
  always_comb begin
    scl      = st.scl_s[1];
    sda      = st.sda_s[1];
    straps   = {st.st2_s[1], st.st1_s[1], st.st0_s[1]};
    scl_rise = scl & ~st.scl_q;
    scl_fall = ~scl & st.scl_q;
    start_c  = scl & st.scl_q & st.sda_q & ~sda; // RL2
    stop_c   = scl & st.scl_q & ~st.sda_q & sda; // RL2
    rx_byte  = {st.shreg[6:0], sda};
    mem_addr = {st.base[12:5], st.prog_idx};
  end

  always_comb begin
    next_st = st;
    buf_we  = 1'b0;
    mem_we  = 1'b0;
    next_st.scl_s = {st.scl_s[0], link.scl};
    next_st.sda_s = {st.sda_s[0], link.sda};
    next_st.wp_s  = {st.wp_s[0], write_protect};
    next_st.st0_s = {st.st0_s[0], select_strap_bit0};
    next_st.st1_s = {st.st1_s[0], select_strap_bit1};
    next_st.st2_s = {st.st2_s[0], select_strap_bit2};
    next_st.scl_q = scl;
    next_st.sda_q = sda;
    // Power-on delay; bus ignored until it ends
    if (!st.ready) begin
      if (st.wait_cnt == 16'(POR_CYC - 1)) begin
        next_st.ready    = 1'b1; // RL21
        next_st.wait_cnt = '0;
      end else begin
        next_st.wait_cnt = st.wait_cnt + 16'h0001;
      end
    end else if (st.busy) begin
      // Program buffered bytes one after another, each a full byte time
      if (st.wait_cnt == 16'(WR_CYC - 1)) begin
        mem_we            = 1'b1; // RL20
        next_st.wait_cnt  = '0;
        next_st.prog_idx  = st.prog_idx + 5'h01;
        next_st.prog_left = st.prog_left - 6'h01;
        if (st.prog_left == 6'h01) begin
          next_st.busy = 1'b0;
        end
      end else begin
        next_st.wait_cnt = st.wait_cnt + 16'h0001;
      end
    end
    if (st.ready) begin
      if (start_c) begin
        next_st.phase     = sm_pkg::SM_CTRL;
        next_st.bitn      = '0;
        next_st.ack_pend  = 1'b0;
        next_st.ack_drive = 1'b0;
        next_st.sda_oe_n  = 1'b1;
      end else if (stop_c) begin
        next_st.sda_oe_n  = 1'b1;
        next_st.ack_drive = 1'b0;
        // Only a STOP after data commits; bytes without it are dropped
        if (st.phase == sm_pkg::SM_DATA && st.count != 6'h00) begin // RL11
          next_st.ptr = {st.base[12:5], 5'(st.base[4:0] + st.count[4:0])}; // RL18 RL16 RL13
          if (!st.wp_s[1]) begin // RL19 RL17
            next_st.busy      = 1'b1;
            next_st.prog_idx  = st.base[4:0];
            next_st.prog_left = (st.count > 6'(sm_pkg::PAGE_BYTES)) ? 6'(sm_pkg::PAGE_BYTES) : st.count;
            next_st.wait_cnt  = '0;
          end
        end
        next_st.phase = sm_pkg::SM_IDLE;
      end else if (st.phase != sm_pkg::SM_IDLE && st.phase != sm_pkg::SM_IGN) begin
        if (scl_rise && st.bitn < 4'(sm_pkg::BITS_PER_BYTE)) begin
          next_st.shreg = rx_byte; // RL4
          next_st.bitn  = st.bitn + 4'h1;
          if (st.bitn == 4'h7) begin
            next_st.ack_pend = 1'b0;
            unique case (st.phase)
              sm_pkg::SM_CTRL: begin
                // Match code and straps; write only; refuse while busy
                if (rx_byte[7:sm_pkg::CTRL_CODE_POS] == sm_pkg::CTRL_CODE &&
                    rx_byte[sm_pkg::CTRL_SEL_POS+:3] == straps &&
                    !rx_byte[sm_pkg::CTRL_RW_POS] && !st.busy) begin // RL5 RL6 RL12
                  next_st.ack_pend = 1'b1; // RL7
                end
              end
              sm_pkg::SM_AH: next_st.ack_pend = 1'b1; // RL9
              sm_pkg::SM_AL: next_st.ack_pend = 1'b1; // RL9
              sm_pkg::SM_DATA: next_st.ack_pend = 1'b1; // RL9
              default: next_st.ack_pend = 1'b0;
            endcase
          end
        end else if (scl_rise && st.bitn == 4'(sm_pkg::BITS_PER_BYTE)) begin
          // Ninth clock: byte is consumed
          next_st.bitn = '0;
          unique case (st.phase)
            sm_pkg::SM_CTRL: next_st.phase = st.ack_pend ? sm_pkg::SM_AH : sm_pkg::SM_IGN; // RL22
            sm_pkg::SM_AH: begin
              next_st.addr_hi = st.shreg[4:0]; // RL8
              next_st.phase   = sm_pkg::SM_AL;
            end
            sm_pkg::SM_AL: begin
              next_st.ptr    = {st.addr_hi, st.shreg}; // RL10
              next_st.base   = {st.addr_hi, st.shreg};
              next_st.wr_idx = st.shreg[4:0];
              next_st.count  = '0;
              next_st.phase  = sm_pkg::SM_DATA;
            end
            sm_pkg::SM_DATA: begin
              buf_we         = 1'b1; // RL14
              next_st.wr_idx = st.wr_idx + 5'h01; // RL15
              next_st.count  = (st.count == 6'h3F) ? st.count : st.count + 6'h01;
            end
            default: next_st.phase = st.phase;
          endcase
        end
        // Drive only after clock falls, so data never moves in high time
        if (scl_fall) begin
          next_st.ack_drive = (st.bitn == 4'(sm_pkg::BITS_PER_BYTE)) && st.ack_pend; // RL1
          next_st.sda_oe_n  = ~next_st.ack_drive;
        end
      end
    end
  end

  // Page buffer holds byte at its page column; overflow overwrites
  always_ff @(posedge pclk) begin
    if (buf_we) begin
      page_buf[st.wr_idx] <= st.shreg;
    end
    if (mem_we) begin
      mem[mem_addr] <= page_buf[st.prog_idx];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{scl_s: 2'h3, sda_s: 2'h3, scl_q: 1'b1, sda_q: 1'b1, sda_oe_n: 1'b1,
              phase: sm_pkg::SM_IDLE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign link.sda_d_o    = 1'b0;
  assign link.sda_d_oe_n = st.sda_oe_n;
  assign busy            = st.busy;
  assign ready           = st.ready;
  assign pointer         = st.ptr;
endmodule

// >>> logic/sm_if.sv
// Two-wire link between the memory device and its master
`timescale 1ns/1ps
interface sm_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_d_o;
  logic sda_d_oe_n;
  wire  scl = scl_oe_n ? 1'b1 : scl_o;
  wire  sda = (sda_m_oe_n | sda_m_o) & (sda_d_oe_n | sda_d_o);
  modport dev (input scl, input sda, output sda_d_o, output sda_d_oe_n);
  modport mst (input scl, input sda, output scl_o, output scl_oe_n, output sda_m_o, output sda_m_oe_n);
endinterface

// >>> logic/sm_mst.sv
// Bus master end: APB-driven write commands onto the two-wire link
`timescale 1ns/1ps
module sm_mst #(
  parameter int HALF = sm_pkg::SCL_HALF_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  sm_if.mst                link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  // 0x0 CMD: write bit0 start, bit1 send, bit2 stop; [15:8] byte. 0x4 STATUS: bit0 busy, bit1 nack
  localparam logic [11:0] OFS_CMD  = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h004;
  typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BYTE, MS_STOP} sm_ms_e;
  typedef struct packed {
    logic [1:0]  sda_s;
    sm_ms_e      op;
    logic [1:0]  ph;
    logic [7:0]  div;
    logic [3:0]  bitn;
    logic [7:0]  data;
    logic        scl;
    logic        sda;
    logic        nack;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sm_mst_s;
  sm_mst_s st;
  sm_mst_s next_st;
  logic    tick;
  logic    acc;

  always_comb begin
    next_st = st;
    next_st.sda_s  = {st.sda_s[0], link.sda};
    next_st.pready = 1'b0;
    tick = (st.div == 8'(HALF - 1));
    acc  = psel & penable & ~st.pready;
    next_st.div = (st.op == MS_IDLE || tick) ? 8'h00 : st.div + 8'h01;
    // APB slave: one wait state, answer in the access phase
    if (acc) begin
      next_st.pready  = 1'b1;
      next_st.pslverr = 1'b0;
      next_st.prdata  = '0;
      if (paddr == OFS_STAT) begin
        if (!pwrite) next_st.prdata = {30'h0, st.nack, st.op != MS_IDLE};
      end else if (paddr == OFS_CMD) begin
        if (pwrite && st.op == MS_IDLE) begin
          next_st.ph   = '0;
          next_st.bitn = '0;
          next_st.data = pwdata[15:8];
          if (pwdata[0]) next_st.op = MS_START;
          else if (pwdata[1]) next_st.op = MS_BYTE;
          else if (pwdata[2]) next_st.op = MS_STOP;
        end
      end else begin
        next_st.pslverr = 1'b1;
      end
    end
    // Clock and conditions; byte data changes only with clock low, START and STOP move data with clock high
    if (tick) begin
      unique case (st.op)
        MS_START: begin
          next_st.ph = st.ph + 2'h1;
          unique case (st.ph)
            2'h0: begin next_st.sda = 1'b1; next_st.scl = 1'b1; end
            2'h1: next_st.sda = 1'b0; // RL3
            2'h2: next_st.scl = 1'b0;
            default: next_st.op = MS_IDLE;
          endcase
        end
        MS_BYTE: begin
          if (!st.scl) begin
            next_st.sda = (st.bitn < 4'h8) ? st.data[7] : 1'b1; // RL1 RL4
            next_st.ph  = 2'h1;
            if (st.ph == 2'h1) next_st.scl = 1'b1;
          end else begin
            next_st.scl  = 1'b0;
            next_st.ph   = 2'h0;
            next_st.data = {st.data[6:0], 1'b0};
            next_st.bitn = st.bitn + 4'h1;
            if (st.bitn == 4'h8) begin
              next_st.nack = st.sda_s[1]; // RL9
              next_st.op   = MS_IDLE;
            end
          end
        end
        MS_STOP: begin
          next_st.ph = st.ph + 2'h1;
          unique case (st.ph)
            2'h0: next_st.sda = 1'b0;
            2'h1: next_st.scl = 1'b1;
            2'h2: next_st.sda = 1'b1; // RL3
            default: next_st.op = MS_IDLE;
          endcase
        end
        default: next_st.op = MS_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{sda_s: 2'h3, op: MS_IDLE, scl: 1'b1, sda: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign link.scl_o      = 1'b0;
  assign link.scl_oe_n   = st.scl;
  assign link.sda_m_o    = 1'b0;
  assign link.sda_m_oe_n = st.sda;
  assign prdata          = st.prdata;
  assign pready          = st.pready;
  assign pslverr         = st.pslverr;
endmodule

// >>> logic/sm_pkg.sv
// Shared constants and types for the serial memory write path
package sm_pkg;
  localparam int          CLK_HZ          = 20000000;
  localparam int          POR_US          = 75;                                   // Power-on reset, longest
  localparam int          POR_CYC_I       = (POR_US * (CLK_HZ / 1000000));
  localparam int          BYTE_WR_US      = 50;                                   // Byte program time
  localparam int          BYTE_WR_CYC     = (BYTE_WR_US * (CLK_HZ / 1000000));
  localparam int          BITS_PER_BYTE   = 8;
  localparam int          PAGE_BYTES      = 32;
  localparam int          ADDR_BITS       = 13;
  localparam int          MEM_BYTES       = 8192;
  localparam logic [3:0]  CTRL_CODE       = 4'hA;
  localparam int          CTRL_CODE_POS   = 4;
  localparam int          CTRL_SEL_POS    = 1;
  localparam int          CTRL_RW_POS     = 0;
  localparam int          SCL_HALF_CYC    = 4;                                    // Master tick, 200 ns; byte clock high one tick, low two
  typedef enum logic [2:0] {SM_IDLE, SM_CTRL, SM_AH, SM_AL, SM_DATA, SM_IGN} sm_phase_e;
endpackage

// >>> tb/i2c_serial_memory_write_path_tb_top.sv
// Bench joining master and device ends, driving the master over APB
`timescale 1ns/1ps
module i2c_serial_memory_write_path_tb_top;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, perr, busy, ready, nk;
  logic        wp = 0;
  logic [2:0]  strap = 3'h5;
  logic [12:0] pointer;
  int          mismatches = 0;
  int          comparisons = 0;
  int          bcyc = 0;
  int          b0 = 0;
  sm_if lnk ();
  sm_dev #(.POR_CYC(20), .WR_CYC(20)) u_sm_dev (.pclk(pclk), .presetn(presetn), .link(lnk),
    .select_strap_bit0(strap[0]), .select_strap_bit1(strap[1]), .select_strap_bit2(strap[2]),
    .write_protect(wp), .busy(busy), .ready(ready), .pointer(pointer));
  sm_mst u_sm_mst (.pclk(pclk), .presetn(presetn), .link(lnk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  sm_link_assertions u_sm_link_assertions (.pclk(pclk), .presetn(presetn), .scl(lnk.scl), .sda(lnk.sda),
    .scl_o(lnk.scl_o), .scl_oe_n(lnk.scl_oe_n), .sda_m_o(lnk.sda_m_o), .sda_m_oe_n(lnk.sda_m_oe_n),
    .sda_d_o(lnk.sda_d_o), .sda_d_oe_n(lnk.sda_d_oe_n));
  always #25 pclk = ~pclk;
  // Busy cycles summed over all internal writes, in clock cycles
  always @(posedge pclk) if (busy === 1'b1) bcyc <= bcyc + 1;
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    #1;
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer; the request holds until pready is sampled high
  // Waits with no cycle limit of its own; only the watchdog ends a hang
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Command to the link, then status polled until the master is idle
  task op(input logic [2:0] bits, input logic [7:0] b);
    apb(1'b1, 12'h000, {16'h0, b, 5'h00, bits});
    rd = 32'h1;
    while (rd[0] !== 1'b0) apb(1'b0, 12'h004, 32'h0);
    nk = rd[1];
  endtask
  task wait_idle;
    while (busy !== 1'b0) @(posedge pclk);
  endtask
  task hdr(input logic [12:0] a);
    op(3'h1, 8'h00); op(3'h2, 8'hAA); check("ctrl ack", nk, 0);
    op(3'h2, {3'h0, a[12:8]}); check("addr hi ack", nk, 0);
    op(3'h2, a[7:0]); check("addr lo ack", nk, 0);
    check("loaded pointer", pointer, a);
  endtask
  task data(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      op(3'h2, 8'(8'h30 + i)); check("data ack", nk, 0);
    end
    b0 = bcyc;
  endtask
  task t_select;
    @(posedge pclk);
    strap <= 3'h2;
    op(3'h1, 8'h00);
    op(3'h2, 8'hA4);
    check("other strap ack", nk, 0);
    op(3'h4, 8'h00);
    strap <= 3'h5;
    op(3'h1, 8'h00); op(3'h2, 8'hA0); check("strap mismatch", nk, 1);
    op(3'h2, 8'h07); check("ignored byte", nk, 1);
    op(3'h1, 8'h00); op(3'h2, 8'hBA); check("code mismatch", nk, 1);
    op(3'h1, 8'h00); op(3'h2, 8'hAB); check("read select", nk, 1);
    op(3'h4, 8'h00);
    apb(1'b0, 12'h008, 32'h0); check("unmapped error", perr, 1);
  endtask
  task t_byte;
    hdr(13'h07FF); data(1); op(3'h4, 8'h00); wait_idle;
    check("byte write time", bcyc - b0, 20);
    check("pointer wrap", pointer, 13'h07E0);
    check("byte stored", u_sm_dev.mem[13'h07FF], 8'h30);
  endtask
  task t_page;
    hdr(13'h087A); data(10); op(3'h4, 8'h00);
    @(posedge pclk); wp <= 1;
    op(3'h1, 8'h00); op(3'h2, 8'hAA); check("busy nack", nk, 1);
    op(3'h4, 8'h00); wait_idle;
    check("page write time", bcyc - b0, 200);
    check("page pointer", pointer, 13'h0864);
    check("page first byte", u_sm_dev.mem[13'h087A], 8'h30);
    check("page last byte", u_sm_dev.mem[13'h0863], 8'h39);
    op(3'h1, 8'h00); op(3'h2, 8'hAA); check("ack after write", nk, 0);
    op(3'h4, 8'h00);
  endtask
  task t_protect;
    hdr(13'h001E); data(3); op(3'h4, 8'h00);
    check("no protected write", bcyc - b0, 0);
    check("protected idle", busy, 0);
    check("protected pointer", pointer, 13'h0001);
    op(3'h1, 8'h00); op(3'h2, 8'hAA); check("ready after protect", nk, 0);
    op(3'h4, 8'h00);
    @(posedge pclk); wp <= 0;
  endtask
  task t_nostop;
    hdr(13'h0100); data(1);
    op(3'h1, 8'h00); op(3'h2, 8'hAA); check("restart ack", nk, 0);
    op(3'h4, 8'h00); wait_idle;
    check("discarded write", bcyc - b0, 0);
    check("kept pointer", pointer, 13'h0100);
  endtask
  task t_wrap;
    hdr(13'h0100); data(33); op(3'h4, 8'h00); wait_idle;
    check("wrapped buffer time", bcyc - b0, 640);
    check("wrapped pointer", pointer, 13'h0101);
    check("overwritten byte", u_sm_dev.mem[13'h0100], 8'h50);
    check("kept second byte", u_sm_dev.mem[13'h0101], 8'h31);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    check("ready early", ready, 0);
    repeat (24) @(posedge pclk);
    check("ready late", ready, 1);
    t_select;
    t_byte;
    t_page;
    t_protect;
    t_nostop;
    t_wrap;
    give_verdict;
  end
  // Cuts a hang short well past the expected run length
  initial begin
    #3000000;
    mismatches++;
    give_verdict;
  end
endmodule

// >>> tb/sm_link_assertions.sv
// Checker watching the two-wire link between master and device
`timescale 1ns/1ps
module sm_link_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic sda_m_o,
  input wire logic sda_m_oe_n,
  input wire logic sda_d_o,
  input wire logic sda_d_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_cnt;
  // Counts clock pulses since START so the ninth slot is known
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      bit_cnt <= 4'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) bit_cnt <= 4'h0;
      else if (scl && !scl_q) bit_cnt <= (bit_cnt == 4'h9) ? 4'h1 : bit_cnt + 4'h1;
    end
  end
  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_ack_begin;
    $fell(sda_d_oe_n);
  endsequence
  a_dev_hold_high: assert property (scl && $past(scl) |-> $stable(sda_d_oe_n)) else $error("device moved data while clock high");
  a_ack_ninth_slot: assert property (scl && scl_q && !sda_d_oe_n |-> bit_cnt == 4'h9) else $error("device drove data outside ninth bit");
  a_start_dev_quiet: assert property (s_start |-> sda_d_oe_n [*8]) else $error("device drove data right after start");
  a_ack_released: assert property (s_ack_begin |-> ##[1:40] sda_d_oe_n) else $error("acknowledge held too long");
  a_ack_clock_low: assert property (s_ack_begin |-> !scl) else $error("acknowledge began with clock high");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*4]) else $error("clock high phase too short");
  a_scl_low_min: assert property ($fell(scl) |-> !scl [*4]) else $error("clock low phase too short");
  a_open_drain: assert property ((sda_d_oe_n || !sda_d_o) && (sda_m_oe_n || !sda_m_o) && (scl_oe_n || !scl_o)) else $error("line driven high");
endmodule
